// >>> verilog/flash_ctrl_regs.svh
// Purpose: Offsets, field positions, key values and timing for the flash sequencer
// Assumes: 40 MHz system clock
// Notes on behaviour
// - Erase flag bit 6 selects erase/program decoding
// - Erase codes: bulk, general, secure, page
// - Program codes: word, row, register byte
// - Unlisted codes start no flash operation
// - Key register write-only, reads zero
// - Start needs 55 then AA key first
// - Erase unit is one 512-instruction page
// - Erase address from table page and offset
// - Stall core during erase, then clear start
// - Row program writes 64 latched instructions
// - Stall core during program, then clear start
`ifndef FLASH_CTRL_REGS_SVH
`define FLASH_CTRL_REGS_SVH

`define SEL_CONTROL      1'b0
`define SEL_KEY          1'b1
`define BIT_START        15
`define BIT_ENABLE       14
`define BIT_ERROR        13
`define BIT_ERASE        6
`define OPCODE_HI        3
`define OPCODE_LO        0
`define KEY_HI           7
`define KEY_LO           0
`define LIDX_HI          6
`define LIDX_LO          1
`define CONTROL_RESET    16'h0000
`define KEY_FIRST        8'h55
`define KEY_SECOND       8'hAA
`define OPC_BULK         4'hF
`define OPC_GEN_SEG      4'hD
`define OPC_SEC_SEG      4'hC
`define OPC_PAGE_ERASE   4'h2
`define OPC_WORD         4'h3
`define OPC_ROW          4'h1
`define OPC_REG_BYTE     4'h0
`define ROW_WORDS        64
`define ROW_LAST         6'h3F
`define PAGE_OFFSET_MASK 16'hFC00
`define ROW_OFFSET_MASK  16'hFF80
`define CLK_PERIOD_NS    25
`define T_ERASE_NS       20000000
`define T_WORD_NS        40000

`endif

// >>> verilog/flash_ctrl_pkg.sv
// Purpose: Types shared by the flash sequencer and its timer
// Assumes: Constants come from flash_ctrl_regs.svh
// Notes: Latch array lives inside the state struct
package flash_ctrl_pkg;

    typedef enum logic [2:0] {
        CMD_NONE      = 3'h0,
        CMD_PAGE      = 3'h1,
        CMD_BULK      = 3'h2,
        CMD_GEN_SEG   = 3'h3,
        CMD_SEC_SEG   = 3'h4,
        CMD_WORD      = 3'h5,
        CMD_ROW       = 3'h6,
        CMD_REG_BYTE  = 3'h7
    } flash_cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_ERASE = 2'b01,
        ST_PROG  = 2'b11,
        ST_DONE  = 2'b10
    } seq_state_t;

    typedef enum logic [1:0] {
        KEY_LOCKED = 2'b00,
        KEY_HALF   = 2'b01,
        KEY_OPEN   = 2'b11
    } key_state_t;

    typedef struct packed {
        logic        we;
        logic        sel;
        logic [15:0] wdata;
    } reg_wr_t;

    typedef struct packed {
        logic        wr_lo;
        logic        wr_hi;
        logic [7:0]  page;
        logic [15:0] offset;
        logic [15:0] data;
    } tbl_wr_t;

    typedef struct packed {
        flash_cmd_t  cmd;
        logic        wstb;
        logic [23:0] addr;
        logic [23:0] wdata;
    } flash_req_t;

    typedef struct packed {
        seq_state_t       seq;
        key_state_t       key;
        logic             start;
        logic             enable;
        logic             error;
        logic             erase;
        logic [3:0]       opcode;
        logic [23:0]      base;
        logic [5:0]       idx;
        logic             stall;
        logic [15:0]      rdata;
        flash_req_t       fl;
        logic [63:0][23:0] latch;
    } ctrl_state_t;

    typedef struct packed {
        logic [19:0] remain;
        logic        run;
        logic        done;
    } tmr_state_t;

endpackage : flash_ctrl_pkg

// >>> verilog/flash_op_timer.sv
// Purpose: Self-timed interval counter for erase and word writes
// Assumes: LOAD is one cycle; COUNT at least 1
// Notes: DONE pulses once, COUNT+1 cycles after LOAD
`timescale 1ns/10ps
module flash_op_timer (
    input  wire logic        CLK,
    input  wire logic        RSTN,
    input  wire logic        LOAD,
    input  wire logic [19:0] COUNT,
    output logic             DONE
);
    import flash_ctrl_pkg::*;

    tmr_state_t t_r;
    tmr_state_t t_nxt;

    // Counts down from COUNT-1 after LOAD; DONE pulses once zero is passed
    always_comb begin
        t_nxt      = t_r;
        t_nxt.done = 1'b0;
        if (LOAD) begin
            t_nxt.remain = COUNT - 20'h00001;
            t_nxt.run    = 1'b1;
        end else if (t_r.run) begin
            if (t_r.remain == 20'h00000) begin
                t_nxt.run  = 1'b0;
                t_nxt.done = 1'b1;
            end else begin
                t_nxt.remain = t_r.remain - 20'h00001;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            t_r <= '0;
        end else begin
            t_r <= t_nxt;
        end
    end

    assign DONE = t_r.done;
endmodule : flash_op_timer

// >>> verilog/flash_program_erase_control.sv
// Purpose: Unlock, decode and self-time flash erase and program operations
// Assumes: Core register and table writes are one-cycle strobes on CLK
// Notes: Read data appears one cycle after REG_SEL changes
`timescale 1ns/10ps
`include "flash_ctrl_regs.svh"
module flash_program_erase_control #(
    parameter int unsigned ERASE_CYCLES =
        (`T_ERASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
    parameter int unsigned WORD_CYCLES  =
        (`T_WORD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
    input  wire logic                    CLK,
    input  wire logic                    RSTN,
    input  wire flash_ctrl_pkg::reg_wr_t REG_WR,
    input  wire logic                    REG_SEL,
    output logic [15:0]                  REG_RDATA,
    input  wire flash_ctrl_pkg::tbl_wr_t TBL_WR,
    output logic                         CPU_STALL,
    output flash_ctrl_pkg::flash_req_t   FLASH_REQ
);
    import flash_ctrl_pkg::*;

    localparam logic [19:0] ERASE_CNT = ERASE_CYCLES[19:0];
    localparam logic [19:0] WORD_CNT  = WORD_CYCLES[19:0];

    ctrl_state_t s_r;
    ctrl_state_t s_nxt;
    logic        tmr_load;
    logic [19:0] tmr_count;
    logic        tmr_done;

    flash_op_timer u_timer (
        .CLK   (CLK),
        .RSTN  (RSTN),
        .LOAD  (tmr_load),
        .COUNT (tmr_count),
        .DONE  (tmr_done)
    );

    // Opcode decode depends on the erase flag
    function automatic flash_cmd_t decode_op(input logic erase, input logic [3:0] op);
        flash_cmd_t c;
        c = CMD_NONE;
        if (erase) begin
            unique case (op)
                `OPC_BULK:       c = CMD_BULK;
                `OPC_GEN_SEG:    c = CMD_GEN_SEG;
                `OPC_SEC_SEG:    c = CMD_SEC_SEG;
                `OPC_PAGE_ERASE: c = CMD_PAGE;
                default:         c = CMD_NONE;
            endcase
        end else begin
            unique case (op)
                `OPC_WORD:       c = CMD_WORD;
                `OPC_ROW:        c = CMD_ROW;
                `OPC_REG_BYTE:   c = CMD_REG_BYTE;
                default:         c = CMD_NONE;
            endcase
        end
        return c;
    endfunction : decode_op

    logic       ctrl_wr;
    logic       key_wr;
    logic       start_req;
    logic       start_ok;
    flash_cmd_t new_cmd;
    logic [7:0] key_byte;

    always_comb begin
        s_nxt     = s_r;
        tmr_load  = 1'b0;
        tmr_count = WORD_CNT;
        ctrl_wr   = REG_WR.we && (REG_WR.sel == `SEL_CONTROL);
        key_wr    = REG_WR.we && (REG_WR.sel == `SEL_KEY);
        key_byte  = REG_WR.wdata[`KEY_HI:`KEY_LO];
        start_req = ctrl_wr && REG_WR.wdata[`BIT_START] && (s_r.seq == ST_IDLE);
        start_ok  = start_req && (s_r.key == KEY_OPEN)
                    && REG_WR.wdata[`BIT_ENABLE];
        new_cmd   = decode_op(REG_WR.wdata[`BIT_ERASE],
                              REG_WR.wdata[`OPCODE_HI:`OPCODE_LO]);
        s_nxt.fl.wstb = 1'b0;

        // Unlock sequence: any other register write in between relocks; table writes do not
        if (key_wr) begin
            if (key_byte == `KEY_FIRST)
                s_nxt.key = KEY_HALF;
            else if (key_byte == `KEY_SECOND && s_r.key == KEY_HALF)
                s_nxt.key = KEY_OPEN;
            else
                s_nxt.key = KEY_LOCKED;
        end else if (ctrl_wr) begin
            s_nxt.key = KEY_LOCKED;
        end

        // Control writes are ignored while an operation runs
        if (ctrl_wr && s_r.seq == ST_IDLE) begin
            s_nxt.enable = REG_WR.wdata[`BIT_ENABLE];
            s_nxt.erase  = REG_WR.wdata[`BIT_ERASE];
            s_nxt.opcode = REG_WR.wdata[`OPCODE_HI:`OPCODE_LO];
            if (!REG_WR.wdata[`BIT_ERROR])
                s_nxt.error = 1'b0;
        end

        // Table writes fill the row latches and capture the target address
        if (TBL_WR.wr_lo) begin
            s_nxt.latch[TBL_WR.offset[`LIDX_HI:`LIDX_LO]][15:0] = TBL_WR.data;
            s_nxt.base = {TBL_WR.page, TBL_WR.offset};
        end
        if (TBL_WR.wr_hi)
            s_nxt.latch[TBL_WR.offset[`LIDX_HI:`LIDX_LO]][23:16] = TBL_WR.data[7:0];

        unique case (s_r.seq)
            ST_IDLE: begin
                if (start_req && !start_ok) begin
                    s_nxt.error = 1'b1;
                end else if (start_ok) begin
                    s_nxt.start  = 1'b1;
                    s_nxt.fl.cmd = new_cmd;
                    s_nxt.idx    = 6'h00;
                    unique case (new_cmd)
                        CMD_PAGE: begin
                            // Whole page around the latched address
                            s_nxt.fl.addr = {s_r.base[23:16],
                                             s_r.base[15:0] & `PAGE_OFFSET_MASK};
                            s_nxt.seq   = ST_ERASE;
                            s_nxt.stall = 1'b1;
                            tmr_load    = 1'b1;
                            tmr_count   = ERASE_CNT;
                        end
                        CMD_BULK, CMD_GEN_SEG, CMD_SEC_SEG: begin
                            s_nxt.fl.addr = s_r.base;
                            s_nxt.seq   = ST_ERASE;
                            s_nxt.stall = 1'b1;
                            tmr_load    = 1'b1;
                            tmr_count   = ERASE_CNT;
                        end
                        CMD_ROW: begin
                            s_nxt.fl.addr  = {s_r.base[23:16],
                                              s_r.base[15:0] & `ROW_OFFSET_MASK};
                            s_nxt.fl.wdata = s_r.latch[0];
                            s_nxt.fl.wstb  = 1'b1;
                            s_nxt.seq   = ST_PROG;
                            s_nxt.stall = 1'b1;
                            tmr_load    = 1'b1;
                        end
                        CMD_WORD, CMD_REG_BYTE: begin
                            s_nxt.fl.addr  = s_r.base;
                            s_nxt.fl.wdata = (new_cmd == CMD_REG_BYTE)
                                ? {16'h0000, s_r.latch[s_r.base[`LIDX_HI:`LIDX_LO]][7:0]}
                                : s_r.latch[s_r.base[`LIDX_HI:`LIDX_LO]];
                            s_nxt.fl.wstb  = 1'b1;
                            s_nxt.seq   = ST_PROG;
                            s_nxt.stall = 1'b1;
                            tmr_load    = 1'b1;
                        end
                        CMD_NONE: s_nxt.seq = ST_DONE;
                    endcase
                end
            end
            ST_ERASE: begin
                if (tmr_done)
                    s_nxt.seq = ST_DONE;
            end
            ST_PROG: begin
                if (tmr_done) begin
                    if (s_r.fl.cmd == CMD_ROW && s_r.idx != `ROW_LAST) begin
                        // Next of the 64 row words, two addresses apart
                        s_nxt.idx      = s_r.idx + 6'h01;
                        s_nxt.fl.addr  = s_r.fl.addr + 24'h000002;
                        s_nxt.fl.wdata = s_r.latch[s_r.idx + 6'h01];
                        s_nxt.fl.wstb  = 1'b1;
                        tmr_load       = 1'b1;
                    end else begin
                        s_nxt.seq = ST_DONE;
                    end
                end
            end
            ST_DONE: begin
                s_nxt.seq    = ST_IDLE;
                s_nxt.start  = 1'b0;
                s_nxt.stall  = 1'b0;
                s_nxt.fl.cmd = CMD_NONE;
            end
        endcase

        // Key register reads as zero in full
        if (REG_SEL == `SEL_KEY) begin
            s_nxt.rdata = 16'h0000;
        end else begin
            s_nxt.rdata = 16'h0000;
            s_nxt.rdata[`BIT_START]  = s_nxt.start;
            s_nxt.rdata[`BIT_ENABLE] = s_nxt.enable;
            s_nxt.rdata[`BIT_ERROR]  = s_nxt.error;
            s_nxt.rdata[`BIT_ERASE]  = s_nxt.erase;
            s_nxt.rdata[`OPCODE_HI:`OPCODE_LO] = s_nxt.opcode;
        end
    end

    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            s_r.seq    <= ST_IDLE;
            s_r.key    <= KEY_LOCKED;
            s_r.start  <= 1'b0;
            s_r.enable <= 1'b0;
            s_r.error  <= 1'b0;
            s_r.erase  <= 1'b0;
            s_r.opcode <= 4'h0;
            s_r.base   <= 24'h000000;
            s_r.idx    <= 6'h00;
            s_r.stall  <= 1'b0;
            s_r.rdata  <= `CONTROL_RESET;
            s_r.fl     <= '{cmd: CMD_NONE, wstb: 1'b0, addr: 24'h000000, wdata: 24'h000000};
            s_r.latch  <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign REG_RDATA = s_r.rdata;
    assign CPU_STALL = s_r.stall;
    assign FLASH_REQ = s_r.fl;

endmodule : flash_program_erase_control

// >>> verif/flash_sw_ref_pkg.sv
// Purpose: Reference decode of operation codes for bench and checker
// Assumes: Command encodings of flash_ctrl_pkg
// Notes: Unlisted codes give no command
package flash_sw_ref_pkg;
    import flash_ctrl_pkg::*;
    function automatic flash_cmd_t ec(input logic er, input logic [3:0] c);
        if (er) begin
            return c == 4'hF ? CMD_BULK : c == 4'hD ? CMD_GEN_SEG :
                   c == 4'hC ? CMD_SEC_SEG : c == 4'h2 ? CMD_PAGE : CMD_NONE;
        end
        return c == 4'h3 ? CMD_WORD : c == 4'h1 ? CMD_ROW :
               c == 4'h0 ? CMD_REG_BYTE : CMD_NONE;
    endfunction : ec
endpackage : flash_sw_ref_pkg

// >>> verif/flash_pe_props.sv
// Purpose: Port-level properties of the flash sequencer
// Assumes: One clock, synchronous active-low reset
// Notes: Key tracking mirrors the unlock order
`timescale 1ns/10ps
module flash_pe_props
    import flash_ctrl_pkg::*, flash_sw_ref_pkg::*;
#(
    parameter int unsigned ERASE_CYCLES = 5,
    parameter int unsigned WORD_CYCLES  = 3
) (
    input wire logic                    CLK,
    input wire logic                    RSTN,
    input wire flash_ctrl_pkg::reg_wr_t REG_WR,
    input wire logic                    REG_SEL,
    input wire logic [15:0]             REG_RDATA,
    input wire flash_ctrl_pkg::tbl_wr_t TBL_WR,
    input wire logic                    CPU_STALL,
    input wire flash_ctrl_pkg::flash_req_t FLASH_REQ
);
    logic        k1_r;
    logic        k2_r;
    logic [19:0] scnt_r;
    logic [6:0]  rn_r;
    logic [23:0] la_r;
    flash_cmd_t  cx;
    wire logic st = REG_WR.we && !REG_WR.sel && REG_WR.wdata[15] && !CPU_STALL;
    wire logic acc = st && k2_r && REG_WR.wdata[14];
    assign cx = ec(REG_WR.wdata[6], REG_WR.wdata[3:0]);
    always_ff @(posedge CLK) begin
        if (!RSTN) begin
            k1_r   <= 1'b0;
            k2_r   <= 1'b0;
            scnt_r <= 20'h0;
            rn_r   <= 7'h0;
            la_r   <= 24'h0;
        end else begin
            if (REG_WR.we) begin
                k1_r <= REG_WR.sel && REG_WR.wdata[7:0] == 8'h55;
                k2_r <= REG_WR.sel && REG_WR.wdata[7:0] == 8'hAA && k1_r;
            end
            scnt_r <= CPU_STALL ? scnt_r + 20'h1 : 20'h0;
            rn_r   <= FLASH_REQ.cmd == CMD_ROW ? rn_r + {6'h0, FLASH_REQ.wstb} : 7'h0;
            if (FLASH_REQ.wstb) la_r <= FLASH_REQ.addr;
        end
    end
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);
    property p_key_rd; $past(REG_SEL) |-> REG_RDATA == 16'h0000; endproperty
    a_key_rd: assert property (p_key_rd) else $error("key reads nonzero");
    property p_decode; acc && cx != CMD_NONE |=> CPU_STALL && FLASH_REQ.cmd == $past(cx);
    endproperty
    a_decode: assert property (p_decode) else $error("no decode");
    property p_unlist; acc && cx == CMD_NONE |=> (!CPU_STALL && !FLASH_REQ.wstb) [*4]; endproperty
    a_unlist: assert property (p_unlist) else $error("unlisted code ran");
    property p_refuse; st && !acc |=> !CPU_STALL [*3]; endproperty
    a_refuse: assert property (p_refuse) else $error("start ran");
    property p_err; st && !acc && !REG_SEL ##1 !REG_SEL |=> REG_RDATA[13]; endproperty
    a_err: assert property (p_err) else $error("error flag not set");
    property p_erase_len; $fell(CPU_STALL) && $past(FLASH_REQ.cmd) inside {CMD_PAGE, CMD_BULK,
        CMD_GEN_SEG, CMD_SEC_SEG} |-> scnt_r >= ERASE_CYCLES && scnt_r <= ERASE_CYCLES + 4;
    endproperty
    a_erase_len: assert property (p_erase_len) else $error("erase stall length");
    property p_clr; $fell(CPU_STALL) && !REG_SEL ##1 !REG_SEL |-> !REG_RDATA[15]; endproperty
    a_clr: assert property (p_clr) else $error("start not cleared");
    property p_gap; FLASH_REQ.wstb |-> CPU_STALL ##1 !FLASH_REQ.wstb [*3]; endproperty
    a_gap: assert property (p_gap) else $error("word strobe spacing");
    property p_row_adr; FLASH_REQ.wstb && FLASH_REQ.cmd == CMD_ROW && rn_r != 7'h0
        |-> FLASH_REQ.addr == la_r + 24'h2; endproperty
    a_row_adr: assert property (p_row_adr) else $error("row address step");
    property p_row_cnt; $past(FLASH_REQ.cmd) == CMD_ROW && FLASH_REQ.cmd != CMD_ROW
        |-> rn_r == 7'h40; endproperty
    a_row_cnt: assert property (p_row_cnt) else $error("row word count");
endmodule : flash_pe_props
bind flash_program_erase_control flash_pe_props #(.ERASE_CYCLES(ERASE_CYCLES),
    .WORD_CYCLES(WORD_CYCLES)) i_flash_pe_props (.CLK(CLK), .RSTN(RSTN), .REG_WR(REG_WR),
    .REG_SEL(REG_SEL), .REG_RDATA(REG_RDATA), .TBL_WR(TBL_WR), .CPU_STALL(CPU_STALL),
    .FLASH_REQ(FLASH_REQ));

// >>> verif/core_sw_model.sv
// Purpose: Core software issuing register and table writes
// Assumes: Tasks are entered just after a rising edge
// Notes: Released lines show inverted values; table data shows the inverse of its low half
`timescale 1ns/10ps
module core_sw_model
    import flash_ctrl_pkg::*;
(
    input  wire logic                 CLK,
    output flash_ctrl_pkg::reg_wr_t   REG_WR,
    output flash_ctrl_pkg::tbl_wr_t   TBL_WR
);
    initial begin
        REG_WR = '0;
        TBL_WR = '0;
    end
    task automatic wr(input logic sel, input logic [15:0] d);
        REG_WR <= '{1'b1, sel, d};
        @(posedge CLK);
        REG_WR <= '{1'b0, sel, ~d};
        @(posedge CLK);
    endtask : wr
    task automatic tw(input logic [7:0] p, input logic [15:0] off, input logic [23:0] d);
        TBL_WR <= '{1'b1, 1'b0, p, off, d[15:0]};
        @(posedge CLK);
        TBL_WR <= '{1'b0, 1'b1, p, off, {8'h00, d[23:16]}};
        @(posedge CLK);
        TBL_WR <= '{1'b0, 1'b0, ~p, ~off, ~d[15:0]};
        @(posedge CLK);
    endtask : tw
    // Set up the operation, then keys and start with no other write between
    task automatic go(input logic [15:0] ctrl);
        wr(1'b0, ctrl & 16'h7FFF);
        wr(1'b1, 16'h0055);
        wr(1'b1, 16'h00AA);
        wr(1'b0, ctrl | 16'h8000);
        @(posedge CLK);
    endtask : go
endmodule : core_sw_model

// >>> verif/tb.sv
// Purpose: Self-checking bench for the flash sequencer
// Assumes: Short erase and word times through parameters
// Notes: Expected flash results are queued and matched by a monitor
`timescale 1ns/10ps
module tb;
    import flash_ctrl_pkg::*;
    import flash_sw_ref_pkg::*;
    typedef struct packed {
        flash_cmd_t  cmd;
        logic        full;
        logic [23:0] addr;
        logic [23:0] wdata;
    } exp_t;
    logic        CLK;
    logic        RSTN;
    logic        REG_SEL;
    logic [15:0] REG_RDATA;
    logic        CPU_STALL;
    reg_wr_t     REG_WR;
    tbl_wr_t     TBL_WR;
    flash_req_t  FLASH_REQ;
    exp_t        expq[$];
    exp_t        e;
    logic        stall_d = 1'b0;
    logic [23:0] lat[64];
    logic [7:0]  pg;
    int          err_total = 0;
    int          cmp_count = 0;
    flash_program_erase_control #(.ERASE_CYCLES(5), .WORD_CYCLES(3))
        i_flash_program_erase_control (.CLK(CLK), .RSTN(RSTN), .REG_WR(REG_WR),
        .REG_SEL(REG_SEL), .REG_RDATA(REG_RDATA), .TBL_WR(TBL_WR),
        .CPU_STALL(CPU_STALL), .FLASH_REQ(FLASH_REQ));
    core_sw_model i_core_sw_model (.CLK(CLK), .REG_WR(REG_WR), .TBL_WR(TBL_WR));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
        cmp_count++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : report_and_stop
    task automatic tbw(input logic [7:0] p, input logic [15:0] off, input logic [23:0] d);
        lat[off[6:1]] = d;
        i_core_sw_model.tw(p, off, d);
    endtask : tbw
    task automatic op(input logic er, input logic [3:0] c, input logic [7:0] p,
                      input logic [15:0] off);
        flash_cmd_t x;
        int         n;
        x = ec(er, c);
        tbw(p, off, 24'($urandom));
        if (x == CMD_ROW) begin
            for (int i = 0; i < 64; i++)
                expq.push_back('{x, 1'b1, {p, off & 16'hFF80} + 24'(2 * i), lat[i]});
        end else if (x == CMD_PAGE) expq.push_back('{x, 1'b1, {p, off & 16'hFC00}, 24'h0});
        else if (x == CMD_REG_BYTE)
            expq.push_back('{x, 1'b1, {p, off}, {16'h0000, lat[off[6:1]][7:0]}});
        else if (x != CMD_NONE) expq.push_back('{x, 1'b1, {p, off}, lat[off[6:1]]});
        i_core_sw_model.go({2'b01, 7'h0, er, 2'b00, c});
        for (n = 0; n < 400 && CPU_STALL !== 1'b0; n++) @(posedge CLK);
        repeat (4) @(posedge CLK);
        chk(n < 400, 1'b1, "done in time");
        chk(REG_RDATA, {9'h080, er, 2'b00, c}, "control after op");
        chk(expq.size(), 0, "results outstanding");
    endtask : op
    always @(posedge CLK) begin
        stall_d <= CPU_STALL;
        if (RSTN && (FLASH_REQ.wstb === 1'b1 || (CPU_STALL && !stall_d &&
            FLASH_REQ.cmd inside {CMD_PAGE, CMD_BULK, CMD_GEN_SEG, CMD_SEC_SEG}))) begin
            if (expq.size() == 0) chk(1'b1, 1'b0, "unexpected flash result");
            else begin
                e = expq.pop_front();
                chk(FLASH_REQ.cmd, e.cmd, "command");
                if (e.full) chk(FLASH_REQ.addr, e.addr, "address");
                if (e.cmd inside {CMD_ROW, CMD_WORD, CMD_REG_BYTE})
                    chk(FLASH_REQ.wdata, e.wdata, "word");
            end
        end
    end
    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end
    initial begin
        repeat (20000) @(posedge CLK);
        err_total++;
        report_and_stop();
    end
    initial begin
        RSTN = 1'b0;
        REG_SEL = 1'b0;
        void'($urandom(32'hF8F84A37));
        pg = 8'($urandom);
        repeat (3) @(posedge CLK);
        RSTN <= 1'b1;
        repeat (2) @(posedge CLK);
        chk(REG_RDATA, 16'h0000, "control at reset");
        for (int r = 0; r < 8; r++) begin
            for (int i = 0; i < 64; i++) tbw(pg + 8'(r), 16'h6000 + 16'(2 * i), 24'($urandom));
            op(1'b0, 4'h1, pg + 8'(r), 16'h6000);
        end
        for (int k = 0; k < 32; k++) op(k[4], k[3:0], pg, 16'($urandom) & 16'hFFFE);
        i_core_sw_model.wr(1'b0, 16'hC042);
        repeat (3) @(posedge CLK);
        chk(REG_RDATA, 16'h6042, "start without key");
        i_core_sw_model.wr(1'b0, 16'h4042);
        chk(REG_RDATA, 16'h4042, "error cleared");
        i_core_sw_model.go(16'h0042);
        repeat (3) @(posedge CLK);
        chk(REG_RDATA, 16'h2042, "start with enable clear");
        i_core_sw_model.wr(1'b1, 16'h0055);
        i_core_sw_model.wr(1'b0, 16'h4042);
        i_core_sw_model.wr(1'b1, 16'h00AA);
        i_core_sw_model.wr(1'b0, 16'hC042);
        repeat (3) @(posedge CLK);
        chk(REG_RDATA, 16'h6042, "broken key order");
        REG_SEL <= 1'b1;
        repeat (2) @(posedge CLK);
        chk(REG_RDATA, 16'h0000, "key read");
        REG_SEL <= 1'b0;
        repeat (2) @(posedge CLK);
        report_and_stop();
    end
endmodule : tb
